// ==== logic/afs_pkg.sv ====
// package of register map, field positions and carrier types for the alarm flag setup block
// assumes one clock, synchronous active-low reset, and a 32-bit AXI4-Lite register bus
// What this block does
// - bit 15 latches the temperature alarm pin
// - bit 14 disables the temperature alarm pin
// - bit 13 latches open-sense on kelvin pin
// - bit 12 removes open-sense from kelvin pin
// - bit 11 latches ground alarm on kelvin
// - bit 10 masks ground alarm, drops pull-up
// - bit 9 latches the clamp alarm pin
// - bit 8 disables the clamp alarm pin
// - bit 7 latches guard alarm on kelvin
// - bit 6 removes guard alarm from kelvin
// - kelvin pin is OR of enabled open-sense, ground and guard alarms
// - status still reports pin-disabled alarms
package afs_pkg;
	// register byte addresses
	localparam logic [7:0] AFS_SETUP_ADDR = 8'h18; // register index 6 times four
	localparam logic [7:0] AFS_SETUP_IDX = 8'h06; // register index
	localparam logic [7:0] AFS_STAT_ADDR = 8'h00; // sticky event status, clear on read
	localparam logic [7:0] AFS_MASK_ADDR = 8'h04; // interrupt mask
	localparam logic [7:0] AFS_LIVE_ADDR = 8'h08; // live alarm levels
	localparam logic [7:0] AFS_CLR_ADDR = 8'h0c; // write ones to clear pin latches
	localparam logic [15:0] AFS_SETUP_RST = 16'h0000; // power-on safe setting
	localparam logic [15:0] AFS_SETUP_WMASK = 16'hffc0; // low six bits unused
	// setup field positions
	localparam int AFS_B_TMP_LAT = 15;
	localparam int AFS_B_TMP_DIS = 14;
	localparam int AFS_B_OS_LAT = 13;
	localparam int AFS_B_OS_DIS = 12;
	localparam int AFS_B_GND_LAT = 11;
	localparam int AFS_B_GND_DIS = 10;
	localparam int AFS_B_CL_LAT = 9;
	localparam int AFS_B_CL_DIS = 8;
	localparam int AFS_B_GRD_LAT = 7;
	localparam int AFS_B_GRD_DIS = 6;
	// alarm source index: 0 temp, 1 open sense, 2 ground, 3 clamp, 4 guard
	localparam int AFS_NSRC = 5;
	localparam logic [1:0] AFS_RESP_OKAY = 2'b00;
	localparam logic [1:0] AFS_RESP_SLVERR = 2'b10;
	// write and read channel payloads
	typedef struct packed {
		logic [7:0] addr;
	} afs_aw_t;
	typedef struct packed {
		logic [31:0] data;
		logic [3:0] strb;
	} afs_w_t;
	typedef struct packed {
		logic [31:0] data;
		logic [1:0] resp;
	} afs_r_t;
endpackage

// ==== logic/afs_sync.sv ====
// two flip-flop synchroniser for the alarm source levels
// assumes sources are asynchronous to mclk_i
module afs_sync #(
	parameter int W = 5
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} afs_sync_st_t;
	afs_sync_st_t st_r, st_nxt;
	// first stage feeds only the second
	always_comb begin
		st_nxt.s1 = d_i;
		st_nxt.s2 = st_r.s1;
	end
	// register stages
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign q_o = st_r.s2;
endmodule // afs_sync

// ==== logic/afs_pin.sv ====
// one alarm path to an open-drain pin: optional latch, then enable
// assumes alarm level already synchronised
module afs_pin (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic alarm_i,
	input wire logic latch_en_i,
	input wire logic disable_i,
	input wire logic clear_i,
	output logic flag_o
);
	typedef struct packed {
		logic held;
	} afs_pin_st_t;
	afs_pin_st_t st_r, st_nxt;
	// latch holds through a clear while the alarm still stands
	always_comb begin
		st_nxt = st_r;
		if (alarm_i && latch_en_i) begin
			st_nxt.held = 1'b1; // set wins over clear
		end else if (clear_i || !latch_en_i) begin
			st_nxt.held = 1'b0;
		end
	end
	// register latch
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	// disabled path never flags
	assign flag_o = !disable_i && (alarm_i || (latch_en_i && st_r.held));
	a_latch_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(latch_en_i && !disable_i && alarm_i && !clear_i) ##1 (latch_en_i && !clear_i && !disable_i)
		|-> flag_o) else $error("latched flag dropped");
	a_unlat_follow: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!latch_en_i |-> (flag_o == (alarm_i && !disable_i))) else $error("unlatched flag wrong");
endmodule // afs_pin

// ==== logic/afs_top.sv ====
// alarm flag setup: setup register, pin latches, kelvin merge, status and interrupt
// assumes AXI4-Lite master on mclk_i; alarm sources come asynchronously, clear comes from a register write
//
// Register access over AXI4-Lite was chosen for this implementation.
module afs_top
	import afs_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	// alarm sources: 0 temp, 1 open sense, 2 ground, 3 clamp, 4 guard
	input wire logic [afs_pkg::AFS_NSRC-1:0] alarm_src_i,
	// open-drain pins: output level low, enable high while pulling
	output logic over_temperature_alarm_pin_o,
	output logic over_temperature_alarm_pin_oe_o,
	output logic clamp_alarm_pin_o,
	output logic clamp_alarm_pin_oe_o,
	output logic kelvin_shared_alarm_pin_o,
	output logic kelvin_shared_alarm_pin_oe_o,
	output logic device_ground_sense_pullup_en_o,
	output logic irq_o,
	// axi4-lite slave
	input wire logic [7:0] s_awaddr_i,
	input wire logic s_awvalid_i,
	output logic s_awready_o,
	input wire logic [31:0] s_wdata_i,
	input wire logic [3:0] s_wstrb_i,
	input wire logic s_wvalid_i,
	output logic s_wready_o,
	output logic [1:0] s_bresp_o,
	output logic s_bvalid_o,
	input wire logic s_bready_i,
	input wire logic [7:0] s_araddr_i,
	input wire logic s_arvalid_i,
	output logic s_arready_o,
	output logic [31:0] s_rdata_o,
	output logic [1:0] s_rresp_o,
	output logic s_rvalid_o,
	input wire logic s_rready_i
);
	import afs_pkg::*;

	// whole module state
	typedef struct packed {
		logic [15:0] setup; // alarm setup register
		logic [AFS_NSRC-1:0] stat; // sticky alarm events
		logic [AFS_NSRC-1:0] mask; // interrupt mask, 1 enables
		logic [AFS_NSRC-1:0] prev; // last alarm levels for edge detect
		logic [AFS_NSRC-1:0] clr; // one-cycle latch clear pulses
		logic aw_have; // write address captured
		afs_aw_t aw;
		logic w_have; // write data captured
		afs_w_t w;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		afs_r_t r;
	} afs_st_t;
	afs_st_t st_r, st_nxt;

	logic [AFS_NSRC-1:0] alarm_s; // synchronised alarm levels
	logic [AFS_NSRC-1:0] flag; // per-source pin contributions
	logic [AFS_NSRC-1:0] lat_en; // latch selects per source
	logic [AFS_NSRC-1:0] dis; // disable selects per source
	logic wr_go; // write commits this cycle
	logic rd_go; // read taken this cycle
	logic [AFS_NSRC-1:0] rise; // alarm onset events

	// true when the address names a mapped register
	function automatic logic afs_mapped(input logic [7:0] a);
		return (a == AFS_SETUP_ADDR) || (a == AFS_STAT_ADDR) || (a == AFS_MASK_ADDR)
			|| (a == AFS_LIVE_ADDR) || (a == AFS_CLR_ADDR);
	endfunction

	// merge a 32-bit write into a 16-bit register by byte strobes
	function automatic logic [15:0] afs_merge(input logic [15:0] old, input afs_w_t wr);
		logic [15:0] v;
		v = old;
		if (wr.strb[0]) begin
			v[7:0] = wr.data[7:0];
		end
		if (wr.strb[1]) begin
			v[15:8] = wr.data[15:8];
		end
		return v;
	endfunction

	// bring alarm levels into the clock domain
	afs_sync #(.W(AFS_NSRC)) u_sync (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.d_i(alarm_src_i),
		.q_o(alarm_s)
	);

	// map setup bits onto each source
	always_comb begin
		lat_en[0] = st_r.setup[AFS_B_TMP_LAT];
		dis[0] = st_r.setup[AFS_B_TMP_DIS];
		lat_en[1] = st_r.setup[AFS_B_OS_LAT];
		dis[1] = st_r.setup[AFS_B_OS_DIS];
		lat_en[2] = st_r.setup[AFS_B_GND_LAT];
		dis[2] = st_r.setup[AFS_B_GND_DIS];
		lat_en[3] = st_r.setup[AFS_B_CL_LAT];
		dis[3] = st_r.setup[AFS_B_CL_DIS];
		lat_en[4] = st_r.setup[AFS_B_GRD_LAT];
		dis[4] = st_r.setup[AFS_B_GRD_DIS];
	end

	// one latch-and-enable path per source
	for (genvar g = 0; g < AFS_NSRC; g++) begin : g_pin
		afs_pin u_pin (
			.mclk_i(mclk_i),
			.nrst_i(nrst_i),
			.alarm_i(alarm_s[g]),
			.latch_en_i(lat_en[g]),
			.disable_i(dis[g]),
			.clear_i(st_r.clr[g]),
			.flag_o(flag[g])
		);
	end

	// open-drain pins: drive low while flagged
	assign over_temperature_alarm_pin_o = 1'b0;
	assign over_temperature_alarm_pin_oe_o = flag[0];
	assign clamp_alarm_pin_o = 1'b0;
	assign clamp_alarm_pin_oe_o = flag[3];
	assign kelvin_shared_alarm_pin_o = 1'b0;
	assign kelvin_shared_alarm_pin_oe_o = flag[1] | flag[2] | flag[4];
	// ground sense pull-up dropped with its alarm
	assign device_ground_sense_pullup_en_o = !st_r.setup[AFS_B_GND_DIS];

	// interrupt: any unmasked sticky event
	assign irq_o = |(st_r.stat & st_r.mask);

	// bus handshakes
	assign s_awready_o = !st_r.aw_have && !st_r.bvalid;
	assign s_wready_o = !st_r.w_have && !st_r.bvalid;
	assign s_bvalid_o = st_r.bvalid;
	assign s_bresp_o = st_r.bresp;
	assign s_arready_o = !st_r.rvalid;
	assign s_rvalid_o = st_r.rvalid;
	assign s_rdata_o = st_r.r.data;
	assign s_rresp_o = st_r.r.resp;

	assign rise = alarm_s & ~st_r.prev;
	assign rd_go = s_arvalid_i && s_arready_o;
	assign wr_go = (st_r.aw_have || s_awvalid_i) && (st_r.w_have || s_wvalid_i) && !st_r.bvalid;

	// next-state: bus slave, registers, status
	always_comb begin
		afs_aw_t aw_c; // address seen this cycle
		afs_w_t w_c; // data seen this cycle
		logic [AFS_NSRC-1:0] stat_clr; // read-clear of status
		aw_c = st_r.aw_have ? st_r.aw : afs_aw_t'(s_awaddr_i);
		w_c = st_r.w_have ? st_r.w : afs_w_t'({s_wdata_i, s_wstrb_i});
		stat_clr = '0;
		st_nxt = st_r;
		st_nxt.prev = alarm_s;
		st_nxt.clr = '0;
		// capture write halves in either order
		if (s_awvalid_i && s_awready_o && !wr_go) begin
			st_nxt.aw_have = 1'b1;
			st_nxt.aw = aw_c;
		end
		if (s_wvalid_i && s_wready_o && !wr_go) begin
			st_nxt.w_have = 1'b1;
			st_nxt.w = w_c;
		end
		// commit write once both halves are here
		if (wr_go) begin
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = afs_mapped(aw_c.addr) ? AFS_RESP_OKAY : AFS_RESP_SLVERR;
			unique case (aw_c.addr)
				AFS_SETUP_ADDR: begin
					// unused low bits kept zero
					st_nxt.setup = afs_merge(st_r.setup, w_c) & AFS_SETUP_WMASK;
				end
				AFS_MASK_ADDR: begin
					if (w_c.strb[0]) begin
						st_nxt.mask = w_c.data[AFS_NSRC-1:0];
					end
				end
				AFS_CLR_ADDR: begin
					if (w_c.strb[0]) begin
						st_nxt.clr = w_c.data[AFS_NSRC-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		if (st_r.bvalid && s_bready_i) begin
			st_nxt.bvalid = 1'b0;
		end
		// read answer one cycle after address
		if (rd_go) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.r.resp = afs_mapped(s_araddr_i) ? AFS_RESP_OKAY : AFS_RESP_SLVERR;
			st_nxt.r.data = '0;
			unique case (s_araddr_i)
				AFS_SETUP_ADDR: begin
					st_nxt.r.data = {16'h0000, st_r.setup};
				end
				AFS_STAT_ADDR: begin
					st_nxt.r.data = {27'h0000000, st_r.stat};
					stat_clr = st_r.stat;
				end
				AFS_MASK_ADDR: begin
					st_nxt.r.data = {27'h0000000, st_r.mask};
				end
				AFS_LIVE_ADDR: begin
					st_nxt.r.data = {27'h0000000, alarm_s};
				end
				default: begin
				end
			endcase
		end else if (st_r.rvalid && s_rready_i) begin
			st_nxt.rvalid = 1'b0;
		end
		// status ignores pin disables; new onset beats read-clear
		st_nxt.stat = (st_r.stat & ~stat_clr) | rise;
	end

	// register state
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			st_r <= '0;
			st_r.setup <= AFS_SETUP_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// checks
	a_tmp_disable: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		st_r.setup[AFS_B_TMP_DIS] |-> !over_temperature_alarm_pin_oe_o)
		else $error("temp pin driven while disabled");
	a_clamp_disable: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		st_r.setup[AFS_B_CL_DIS] |-> !clamp_alarm_pin_oe_o)
		else $error("clamp pin driven while disabled");
	a_kel_merge: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		kelvin_shared_alarm_pin_oe_o == (flag[1] | flag[2] | flag[4]))
		else $error("kelvin pin not merged");
	a_kel_os_off: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(st_r.setup[AFS_B_OS_DIS] && !flag[2] && !flag[4]) |-> !kelvin_shared_alarm_pin_oe_o)
		else $error("open sense flagged while off");
	a_kel_guard_off: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(st_r.setup[AFS_B_GRD_DIS] && !flag[1] && !flag[2]) |-> !kelvin_shared_alarm_pin_oe_o)
		else $error("guard flagged while off");
	a_gnd_pullup: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		st_r.setup[AFS_B_GND_DIS] |-> (!device_ground_sense_pullup_en_o && !flag[2]))
		else $error("ground pull-up or flag left on");
	a_stat_report: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(alarm_s[0] && !st_r.prev[0]) |=> st_r.stat[0])
		else $error("disabled alarm not reported");
	a_tmp_unlat: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(!st_r.setup[AFS_B_TMP_LAT] && !st_r.setup[AFS_B_TMP_DIS])
		|-> (over_temperature_alarm_pin_oe_o == alarm_s[0]))
		else $error("temp pin not following alarm");
	a_setup_low: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		st_r.setup[5:0] == 6'h00) else $error("unused setup bits set");
	a_clamp_latch: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(st_r.setup[AFS_B_CL_LAT] && !st_r.setup[AFS_B_CL_DIS] && alarm_s[3] && !st_r.clr[3])
		##1 (st_r.setup[AFS_B_CL_LAT] && !st_r.setup[AFS_B_CL_DIS] && !st_r.clr[3])
		|-> clamp_alarm_pin_oe_o) else $error("clamp latch lost");
endmodule // afs_top

// ==== bench/afs_alarm_monitor.sv ====
// tester-side monitor of the three open-drain alarm pins
// assumes a board pull-up on each pin and a block that only pulls low
module afs_alarm_monitor (
	input wire logic [2:0] pin_lvl_i, // driven level: temp, clamp, kelvin
	input wire logic [2:0] pin_oe_i, // high while the block pulls the pin
	output logic [2:0] wire_o // resolved wire, low means alarm
);
	timeunit 1ns;
	timeprecision 1ps;
	// a released pin floats up to the pull-up level
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			wire_o[k] = pin_oe_i[k] ? pin_lvl_i[k] : 1'b1;
		end
	end
endmodule // afs_alarm_monitor

// ==== bench/tb.sv ====
// self-checking bench for the alarm flag setup block
// assumes pull-ups on the pins, modelled by the alarm monitor
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import afs_pkg::*;
	logic mclk = 1'b0; // 250 MHz
	logic rst_n = 1'b0; // sync reset, low active
	logic [4:0] src = 5'h00; // alarm sources
	logic [7:0] awaddr = 8'h00; // write address
	logic [7:0] araddr = 8'h00; // read address
	logic [31:0] wdata = 32'h0; // write data
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, irq, pull_en;
	logic [1:0] bresp, rresp; // responses
	logic [31:0] rdata; // read data
	logic [2:0] lvl, oe, pins; // temp, clamp, kelvin
	logic [31:0] rd_d; // last read data
	logic [1:0] rsp; // last response
	int err_total = 0;
	int compares = 0;
	// pins pulled by one source alone: temp, open sense, ground, clamp, guard
	logic [2:0] lone [5] = '{3'b110, 3'b011, 3'b011, 3'b101, 3'b011};
	// disable bit of each source
	logic [15:0] dis [5] = '{16'h4000, 16'h1000, 16'h0400, 16'h0100, 16'h0040};

	// clock, 4 ns period
	always #2 mclk = ~mclk;

	afs_top i_afs_top (
		.mclk_i(mclk), .nrst_i(rst_n), .alarm_src_i(src),
		.over_temperature_alarm_pin_o(lvl[0]), .over_temperature_alarm_pin_oe_o(oe[0]),
		.clamp_alarm_pin_o(lvl[1]), .clamp_alarm_pin_oe_o(oe[1]),
		.kelvin_shared_alarm_pin_o(lvl[2]), .kelvin_shared_alarm_pin_oe_o(oe[2]),
		.device_ground_sense_pullup_en_o(pull_en), .irq_o(irq),
		.s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
		.s_wdata_i(wdata), .s_wstrb_i(4'hf), .s_wvalid_i(wvalid), .s_wready_o(wready),
		.s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
		.s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
		.s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready)
	);
	afs_alarm_monitor i_afs_alarm_monitor (.pin_lvl_i(lvl), .pin_oe_i(oe), .wire_o(pins));

	// compare one value and count it
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// let alarm levels cross the synchroniser and latch
	task automatic settle;
		repeat (5) @(posedge mclk);
	endtask
	// one write, both halves offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_p, w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (bvalid) begin
				rsp = bresp;
				bready <= 1'b0;
				break;
			end
			if (aw_p && awready) begin
				aw_p = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_p && wready) begin
				w_p = 1'b0;
				wvalid <= 1'b0;
			end
		end
	endtask
	// one read into rd_d and rsp
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (rvalid) begin
				rd_d = rdata;
				rsp = rresp;
				rready <= 1'b0;
				break;
			end
			if (arready) begin
				arvalid <= 1'b0;
			end
		end
	endtask
	// reset values, read-back, unmapped place
	task automatic t_regs;
		rd(AFS_SETUP_ADDR);
		chk("setup reset", 32'h0, rd_d);
		chk("pins idle", 3'b111, pins);
		chk("pull-up reset", 1'b1, pull_en);
		wr(AFS_SETUP_ADDR, 32'h5540);
		chk("setup resp", AFS_RESP_OKAY, rsp);
		rd(AFS_SETUP_ADDR);
		chk("setup back", 32'h5540, rd_d);
		rd(8'h40);
		chk("unmapped resp", AFS_RESP_SLVERR, rsp);
		chk("unmapped data", 32'h0, rd_d);
		wr(AFS_SETUP_ADDR, 32'h0);
	endtask
	// each source alone, pins follow it both ways
	task automatic t_open;
		for (int i = 0; i < 5; i++) begin
			src <= 5'h01 << i;
			settle();
			chk("unlatched on", lone[i], pins);
			src <= 5'h00;
			settle();
			chk("unlatched off", 3'b111, pins);
		end
	endtask
	// one disable bit at a time, status still counts
	task automatic t_mask;
		for (int i = 0; i < 5; i++) begin
			wr(AFS_SETUP_ADDR, {16'h0, dis[i]});
			rd(AFS_STAT_ADDR);
			src <= 5'h01 << i;
			settle();
			chk("masked pin", 3'b111, pins);
			chk("pull-up", i != 2, pull_en);
			src <= 5'h1f;
			settle();
			chk("others pin", {1'b0, i == 3, i == 0}, pins);
			rd(AFS_LIVE_ADDR);
			chk("live levels", 32'h1f, rd_d);
			src <= 5'h00;
			settle();
			rd(AFS_STAT_ADDR);
			chk("status", 32'h1f, rd_d);
		end
		wr(AFS_SETUP_ADDR, 32'h0);
	endtask
	// latched pins hold a short pulse until cleared
	task automatic t_latch;
		wr(AFS_SETUP_ADDR, 32'haa80);
		for (int i = 0; i < 5; i++) begin
			src <= 5'h01 << i;
			settle();
			src <= 5'h00;
			settle();
			chk("latched hold", lone[i], pins);
			wr(AFS_CLR_ADDR, 32'h1f);
			settle();
			chk("latch cleared", 3'b111, pins);
		end
		wr(AFS_SETUP_ADDR, 32'h0);
	endtask
	// interrupt masked, unmasked, cleared by status read
	task automatic t_irq;
		rd(AFS_STAT_ADDR);
		wr(AFS_MASK_ADDR, 32'h0);
		src <= 5'h08;
		settle();
		src <= 5'h00;
		settle();
		chk("irq masked", 1'b0, irq);
		wr(AFS_MASK_ADDR, 32'h1f);
		repeat (2) @(posedge mclk);
		chk("irq raised", 1'b1, irq);
		rd(AFS_STAT_ADDR);
		chk("irq status", 32'h08, rd_d);
		repeat (2) @(posedge mclk);
		chk("irq cleared", 1'b0, irq);
	endtask
	// verdict and end of run
	task automatic tally_and_finish;
		if (err_total == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs();
		t_open();
		t_mask();
		t_latch();
		t_irq();
		tally_and_finish();
	end
	// watchdog, far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		tally_and_finish();
	end
endmodule // tb
